// ---- logic/pado_core.sv ----
// Purpose: digital half of a pipelined 10-bit converter
// Assumes: analogIn is the held sample, on ref_clk
// Notes: pins outEnableN and sleepPin are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "pado_defs.svh"
// Function
// - each sample runs through nine two-bit stages passing residues.
// - every stage converts once per convert clock, one new sample a clock.
// - each stage code but the last is delayed to line up with the last stage's code.
// - aligned codes are merged by redundancy correction into 10 bits.
// - a word appears five clocks after its sample's conversion start.
// - data lines are gated by an active-low output enable input.
// - line 1 carries the top result bit and line 10 the bottom bit.
// - coding is straight offset binary, mid-scale is the top bit alone.
// - data lines float while output enable is high, drive while it is low and sleep is low.
// - a high sleep input powers down and floats the data lines.
// - the seven words after sleep is released are invalid.
module pado_core
  import pado_pkg::*;
#(
  parameter int FIFO_DEPTH = `PADO_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`PADO_IN_W-1:0] analogIn,
  input wire logic outEnableN,
  input wire logic sleepPin,
  output logic [1:10] dataPin,
  output logic dataPinOe,
  output logic wordValid,
  output logic [`PADO_RES_W-1:0] tapData,
  output logic tapValid,
  input wire logic tapReady,
  output logic tapAccept
);
  if (FIFO_DEPTH < 16) begin : g_bad_fifo
    $error("pado_core needs a tap buffer of at least 16 words");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic oeMeta_q, oeSync_q, sleepMeta_q, sleepSync_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oeMeta_q <= 1'b1;
      oeSync_q <= 1'b1;
      sleepMeta_q <= 1'b0;
      sleepSync_q <= 1'b0;
    end else begin
      oeMeta_q <= outEnableN;
      oeSync_q <= oeMeta_q;
      sleepMeta_q <= sleepPin;
      sleepSync_q <= sleepMeta_q;
    end
  end

  // ----------------------------------------
  // power state
  // ----------------------------------------
  pado_pwr_e pwr_q, pwr_d;
  logic [2:0] wakeCnt_q, wakeCnt_d;
  logic convEn;

  always_comb begin
    pwr_d = pwr_q;
    wakeCnt_d = wakeCnt_q;
    case (pwr_q)
      PWR_RUN: begin
        if (sleepSync_q) pwr_d = PWR_SLEEP;
      end
      PWR_SLEEP: begin
        wakeCnt_d = 3'h0;
        if (!sleepSync_q) pwr_d = PWR_WAKE;
      end
      PWR_WAKE: begin
        if (sleepSync_q) begin
          pwr_d = PWR_SLEEP;
        end else if (wakeCnt_q == 3'(`PADO_WAKE_CYC - 1)) begin
          pwr_d = PWR_RUN;
        end else begin
          wakeCnt_d = wakeCnt_q + 3'h1;
        end
      end
      default: pwr_d = PWR_SLEEP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwr_q <= PWR_WAKE;
      wakeCnt_q <= 3'h0;
    end else begin
      pwr_q <= pwr_d;
      wakeCnt_q <= wakeCnt_d;
    end
  end

  // stage clock enable
  // stages only stand still in power-down; stale words are then masked
  assign convEn = pwr_q != PWR_SLEEP;
  assign wordValid = pwr_q == PWR_RUN;

  // ----------------------------------------
  // quantizer chain
  // ----------------------------------------
  pado_res_t hold_q, hold_d;
  pado_res_t res_q [4];
  pado_res_t res_d [4];
  logic [1:0] code [`PADO_STAGES];

  // nine stage chain
  // two stages per clock, both evaluated in the same clock cycle
  always_comb begin
    pado_stage_s a;
    pado_stage_s b;
    a = '0;
    b = '0;
    hold_d = convEn ? $signed({2'b00, analogIn}) - `PADO_MID_IN : hold_q;
    for (int r = 0; r < 4; r++) begin
      a = pado_stage(r == 0 ? hold_q : res_q[r == 0 ? 0 : r - 1]);
      b = pado_stage(a.res);
      code[2 * r] = a.code;
      code[2 * r + 1] = b.code;
      res_d[r] = convEn ? b.res : res_q[r];
    end
    code[8] = pado_last(res_q[3]);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_q <= '0;
      res_q <= '{default: '0};
    end else begin
      hold_q <= hold_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------
  // alignment delay lines
  // ----------------------------------------
  logic [1:0] codeAl [`PADO_STAGES];

  for (genvar k = 0; k < `PADO_STAGES; k++) begin : g_dly
    localparam int DEP = 4 - k / 2;
    if (DEP == 0) begin : g_none
      assign codeAl[k] = code[k];
    end else begin : g_line
      logic [1:0] dl_q [DEP];
      logic [1:0] dl_d [DEP];
      always_comb begin
        for (int i = 0; i < DEP; i++) begin
          dl_d[i] = convEn ? (i == 0 ? code[k] : dl_q[i == 0 ? 0 : i - 1])
                           : dl_q[i];
        end
      end
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          dl_q <= '{default: 2'h0};
        end else begin
          dl_q <= dl_d;
        end
      end
      assign codeAl[k] = dl_q[DEP-1];
    end
  end

  // ----------------------------------------
  // correction and output word
  // ----------------------------------------
  pado_word_t word_q, word_d;

  // offset binary sum
  // one-bit overlap between stages absorbs comparator offsets
  always_comb begin
    pado_word_t sum;
    sum = '0;
    for (int k = 0; k < `PADO_STAGES - 1; k++) begin
      sum = sum + pado_word_t'({8'h00, codeAl[k]} << (8 - k));
    end
    sum = sum + pado_word_t'(codeAl[8]);
    word_d = convEn ? sum : word_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  // line 1 is the top bit
  assign dataPin = word_q;
  assign dataPinOe = !oeSync_q && !sleepSync_q;

  // ----------------------------------------
  // capture tap buffer
  // ----------------------------------------
  // a full buffer drops words: the converter itself cannot be stalled
  pado_fifo #(
    .W(`PADO_RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tap (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(wordValid),
    .inReady(tapAccept),
    .inData(word_q),
    .outValid(tapValid),
    .outReady(tapReady),
    .outData(tapData)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_word_latency: assert property (@(posedge ref_clk) disable iff (reset)
    wordValid |-> word_q == pado_convert($past(hold_q, 5)))
    else $error("word does not match sample of five clocks back");
  chk_mid_code: assert property (@(posedge ref_clk) disable iff (reset)
    wordValid && $past(hold_q, 5) == 14'sh0000 |-> word_q == `PADO_MID_CODE)
    else $error("mid-scale sample not coded as top bit alone");
  chk_neg_full: assert property (@(posedge ref_clk) disable iff (reset)
    wordValid && $past(hold_q, 5) == -`PADO_ONE |-> word_q == 10'h000)
    else $error("negative full scale not coded as zero");
  chk_oe_gate: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(outEnableN) |-> ##[1:3] !dataPinOe)
    else $error("data lines still driven after enable went high");
  chk_oe_drive: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) && !$past(reset, 2)
      |-> dataPinOe == (!$past(outEnableN, 2) && !$past(sleepPin, 2)))
    else $error("data lines not driven while enabled");
  chk_sleep_float: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) && !$past(reset, 2) && $past(sleepPin, 2)
      |-> !dataPinOe ##1 !convEn)
    else $error("lines driven or stages running in power-down");
  chk_wake_gap: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(sleepSync_q) |-> !wordValid [*6])
    else $error("word marked valid too soon after wake");
  chk_bit_order: assert property (@(posedge ref_clk) disable iff (reset)
    wordValid |-> dataPin[1] == ($past(hold_q, 5) >= 14'sh0000))
    else $error("pin order of result bits wrong");
  chk_stage_tick: assert property (@(posedge ref_clk) disable iff (reset)
    convEn |=> hold_q == $signed({2'b00, $past(analogIn)}) - `PADO_MID_IN)
    else $error("sample not taken on a running clock");
  chk_code_align: assert property (@(posedge ref_clk) disable iff (reset)
    convEn [*5] |=> codeAl[0] == $past(code[0], 4))
    else $error("first stage code not delayed four clocks");
  // reference residue of the first stage pair
  pado_stage_s chkOne, chkTwo;
  always_comb begin
    chkOne = pado_stage(hold_q);
    chkTwo = pado_stage(chkOne.res);
  end
  chk_stage_count: assert property (@(posedge ref_clk) disable iff (reset)
    convEn |=> res_q[0] == $past(chkTwo.res)
      && res_q[0] <= `PADO_ONE && res_q[0] >= -`PADO_ONE)
    else $error("stage pair residue wrong");

  cov_wake_run: cover property (@(posedge ref_clk) disable iff (reset)
    pwr_q == PWR_WAKE ##1 pwr_q == PWR_RUN);
  cov_sleep: cover property (@(posedge ref_clk) disable iff (reset)
    pwr_q == PWR_RUN ##1 pwr_q == PWR_SLEEP);
  cov_tap_full: cover property (@(posedge ref_clk) disable iff (reset)
    wordValid && !tapAccept);
endmodule
`default_nettype wire

// ---- logic/pado_defs.svh ----
// Purpose: shared constants of the converter output path
// Assumes: ref_clk is the convert clock
// Notes: residues are signed, 11 fraction bits, 1.0 = 2048
`ifndef PADO_DEFS_SVH
`define PADO_DEFS_SVH
`define PADO_STAGES 9
`define PADO_RES_W 10
`define PADO_IN_W 12
`define PADO_LAT_CYC 5
`define PADO_WAKE_CYC 5
`define PADO_FIFO_DEPTH 16
`define PADO_MID_IN 14'sh0800
`define PADO_ONE 14'sh0800
`define PADO_HALF 14'sh0400
`define PADO_QTR 14'sh0200
`define PADO_MID_CODE 10'h200
`endif

// ---- logic/pado_fifo.sv ----
// Purpose: word buffer on the capture tap
// Assumes: single clock, synchronous active-high reset
// Notes: DEPTH must be a power of two
`timescale 1ns/1ps
`default_nettype none
module pado_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pado_fifo depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = count_q != (AW + 1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule
`default_nettype wire

// ---- logic/pado_pkg.sv ----
// Purpose: types and quantizer arithmetic of the output path
// Assumes: constants from pado_defs.svh
// Notes: pado_convert is the whole chain in one call
`include "pado_defs.svh"
package pado_pkg;
  typedef logic signed [13:0] pado_res_t;
  typedef logic [`PADO_RES_W-1:0] pado_word_t;
  typedef struct packed {
    pado_res_t res;
    logic [1:0] code;
  } pado_stage_s;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_WAKE = 3'b100
  } pado_pwr_e;

  // redundant stage: code 0..2, residue doubled and re-centred
  function automatic pado_stage_s pado_stage(input pado_res_t v);
    pado_stage_s s;
    s.code = 2'd1;
    s.res = v <<< 1;
    if (v >= `PADO_QTR) begin
      s.code = 2'd2;
      s.res = (v <<< 1) - `PADO_ONE;
    end else if (v < -`PADO_QTR) begin
      s.code = 2'd0;
      s.res = (v <<< 1) + `PADO_ONE;
    end
    return s;
  endfunction

  // final stage is a plain two-bit flash
  function automatic logic [1:0] pado_last(input pado_res_t v);
    if (v < -`PADO_HALF) return 2'd0;
    if (v < 14'sh0000) return 2'd1;
    if (v < `PADO_HALF) return 2'd2;
    return 2'd3;
  endfunction

  function automatic pado_word_t pado_convert(input pado_res_t v);
    pado_stage_s s;
    pado_word_t w;
    s.res = v;
    s.code = 2'd0;
    w = '0;
    for (int k = 0; k < `PADO_STAGES - 1; k++) begin
      s = pado_stage(s.res);
      w = w + pado_word_t'({8'h00, s.code} << (8 - k));
    end
    w = w + pado_word_t'(pado_last(s.res));
    return w;
  endfunction
endpackage

// ---- verification/pado_sink.sv ----
// Purpose: downstream logic that latches the parallel sample word
// Assumes: ref_clk is the convert clock, pins driven from bench levels
// Notes: released data lines show the inverse of the last driven word
`timescale 1ns/1ps
`default_nettype none
module pado_sink (
  input wire logic ref_clk,
  input wire logic [1:10] dataPin,
  input wire logic dataPinOe,
  input wire logic wordValid,
  input wire logic tapValid,
  input wire logic wantFloat,
  input wire logic stall,
  output logic outEnableN,
  output logic tapReady,
  output logic [9:0] lineLevel,
  output int capCount,
  output int popCount
);
  // --------------------------------------------------------------
  // pins and capture
  // --------------------------------------------------------------
  logic [9:0] lastDriven = '0;
  int capQ = 0;
  int popQ = 0;
  assign capCount = capQ;
  assign popCount = popQ;
  // enable held low while words are expected
  assign outEnableN = wantFloat;
  assign tapReady = !stall;
  // no pull on data lines, so a floating line is not trusted
  assign lineLevel = dataPinOe ? dataPin : ~lastDriven;
  always @(posedge ref_clk) begin
    if (dataPinOe) begin
      lastDriven <= dataPin;
    end
    // one word per clock, invalid ones dropped
    if (dataPinOe && wordValid) begin
      capQ <= capQ + 1;
    end
    if (tapValid && tapReady) begin
      popQ <= popQ + 1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_pipelined_adc_output_path.sv ----
// Purpose: self-checking bench of the converter output path
// Assumes: inputs change on the falling edge of ref_clk
// Notes: expected words are the 12-bit input with two low bits dropped
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_adc_output_path;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] analogIn = 12'h800;
  logic sleepPin = 1'b0;
  logic wantFloat = 1'b0;
  logic stall = 1'b0;
  logic outEnableN, tapReady, dataPinOe, wordValid, tapValid, tapAccept;
  logic [1:10] dataPin;
  logic [9:0] tapData, lineLevel;
  int capCount, popCount;
  int num_errors = 0;
  int n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  pado_core u_pado_core (.ref_clk(ref_clk), .reset(reset),
    .analogIn(analogIn), .outEnableN(outEnableN), .sleepPin(sleepPin),
    .dataPin(dataPin), .dataPinOe(dataPinOe), .wordValid(wordValid),
    .tapData(tapData), .tapValid(tapValid), .tapReady(tapReady),
    .tapAccept(tapAccept));
  pado_sink u_pado_sink (.ref_clk(ref_clk), .dataPin(dataPin),
    .dataPinOe(dataPinOe), .wordValid(wordValid), .tapValid(tapValid),
    .wantFloat(wantFloat), .stall(stall), .outEnableN(outEnableN),
    .tapReady(tapReady), .lineLevel(lineLevel), .capCount(capCount),
    .popCount(popCount));
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // bounded wait, a hang counts as a mismatch
  task automatic wait_valid();
    int k;
    k = 0;
    while (wordValid !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    if (wordValid !== 1'b1) begin
      check({9'h0, wordValid}, 10'h001);
      give_verdict();
    end
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_reset();
    tick(12);
    check({9'h0, wordValid}, 10'h000);
    check({9'h0, tapValid}, 10'h000);
    check({9'h0, tapAccept}, 10'h001);
    reset = 1'b0;
    // words of the first pipeline pass are masked
    repeat (4) begin
      tick(1);
      check({9'h0, wordValid}, 10'h000);
    end
    wait_valid();
    $display("test reset done");
  endtask
  task automatic test_stream();
    logic [11:0] vals [8];
    logic [9:0] exp;
    int c0;
    vals = '{12'h000, 12'h400, 12'h800, 12'ha00, 12'hc00, 12'hfff,
      12'h800, 12'h000};
    c0 = capCount;
    for (int i = 0; i < 14; i++) begin
      tick(1);
      if (i >= 6) begin
        exp = vals[i-6][11:2];
        check(dataPin, exp);
        check(lineLevel, exp);
        check({9'h0, dataPin[1]}, {9'h0, exp[9]});
        check({9'h0, dataPin[10]}, {9'h0, exp[0]});
        check({9'h0, wordValid}, 10'h001);
      end
      if (i < 8) begin
        analogIn = vals[i];
      end
    end
    // every clock of the run hands the sink one valid word
    check(10'(capCount - c0), 10'd14);
    $display("test stream done");
  endtask
  task automatic test_enable();
    wantFloat = 1'b1;
    tick(3);
    check({9'h0, dataPinOe}, 10'h000);
    wantFloat = 1'b0;
    tick(3);
    check({9'h0, dataPinOe}, 10'h001);
    $display("test enable done");
  endtask
  task automatic test_sleep();
    analogIn = 12'hc00;
    sleepPin = 1'b1;
    tick(4);
    check({9'h0, dataPinOe}, 10'h000);
    sleepPin = 1'b0;
    repeat (5) begin
      tick(1);
      check({9'h0, wordValid}, 10'h000);
    end
    wait_valid();
    check(dataPin, 10'h300);
    check({9'h0, dataPinOe}, 10'h001);
    $display("test sleep done");
  endtask
  task automatic test_fifo();
    int p0;
    int k;
    logic [9:0] lastWord;
    analogIn = 12'h400;
    stall = 1'b1;
    tick(30);
    check({9'h0, tapAccept}, 10'h000);
    check({9'h0, tapValid}, 10'h001);
    // oldest word is the first valid one after the last wake
    check(tapData, 10'h300);
    // power down so no new word lands while draining
    sleepPin = 1'b1;
    tick(4);
    p0 = popCount;
    lastWord = '0;
    stall = 1'b0;
    k = 0;
    while (tapValid === 1'b1 && k < 40) begin
      lastWord = tapData;
      tick(1);
      k++;
    end
    check(10'(popCount - p0), 10'd16);
    check({9'h0, tapValid}, 10'h000);
    // newest word held is the last one accepted before the buffer filled
    check(lastWord, 10'h100);
    sleepPin = 1'b0;
    wait_valid();
    $display("test fifo done");
  endtask
  initial begin
    test_reset();
    test_stream();
    test_enable();
    test_sleep();
    test_fifo();
    give_verdict();
  end
endmodule
`default_nettype wire
